// File: spg_ctrl.sv
/*
  Host controller: software posts one flash bus cycle at a time over
  AHB-Lite; this module drives the flash pins and enforces the host's
  obligations for protection sequences.
  Assumes the flash is the only target and inputs are synchronous to hclk.
*/
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module spg_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [spg_pkg::ADDR_W-1:0] fl_addr,
  output logic [spg_pkg::DQ_W-1:0] fl_dq_o,
  input wire logic [spg_pkg::DQ_W-1:0] fl_dq_i,
  output logic fl_dq_oe,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic fl_reset_n,
  output logic write_protect_accel_pin
);
  import spg_pkg::*;

  spg_state_t state;
  logic [3:0] ctrl;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] wdata;
  logic [DQ_W-1:0] rdata;
  logic [4:0] cmd;
  logic err;
  logic ph_wr;
  logic [7:0] ph_addr;
  logic [7:0] cnt;
  logic [7:0] gap;
  logic wp_hold;
  logic go;
  logic refuse;
  logic busy;

  // The slave never stretches a transfer and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign busy = (state != SPG_IDLE);

  // Register offset decode, shared by read and write paths.
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
    is_reg = (a == r);
  endfunction : is_reg

  // Sector zero is any address whose sector field is all zero.
  function automatic logic sect0(input logic [ADDR_W-1:0] a);
    sect0 = (a[ADDR_W-1:SECT_LSB] == '0);
  endfunction : sect0

  // Address phase capture for writes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_addr <= 8'h00;
    end else if (clk_en && hready) begin
      ph_wr <= hsel && htrans[1] && hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  // Read data is registered in the address phase so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (clk_en && hready && hsel && htrans[1] && !hwrite) begin
      unique case (1'b1)
        is_reg(haddr[7:0], REG_CTRL): hrdata <= {28'h0, ctrl};
        is_reg(haddr[7:0], REG_ADDR): hrdata <= {6'h0, addr};
        is_reg(haddr[7:0], REG_WDATA): hrdata <= {16'h0, wdata};
        is_reg(haddr[7:0], REG_CMD): hrdata <= {27'h0, cmd};
        is_reg(haddr[7:0], REG_STAT): hrdata <= {30'h0, err, busy};
        is_reg(haddr[7:0], REG_RDATA): hrdata <= {16'h0, rdata};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // A write to the command offset while idle launches one flash cycle.
  assign go = clk_en && ph_wr && is_reg(ph_addr, REG_CMD) && !busy;

  // [RQ14] mode and sector gating
  // Protection cycles need the mode entered; array cycles may not touch sector 0 in it.
  assign refuse = (hwdata[CMD_PROT] && !ctrl[CTRL_MODE]) ||
                  (hwdata[CMD_ARRAY] && ctrl[CTRL_MODE] && sect0(addr));

  // Software registers; address and data are frozen while a cycle runs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
      addr <= '0;
      wdata <= '0;
      cmd <= 5'h00;
    end else if (clk_en && ph_wr) begin
      if (is_reg(ph_addr, REG_CTRL)) begin
        ctrl <= hwdata[3:0];
      end
      if (is_reg(ph_addr, REG_ADDR) && !busy) begin
        addr <= hwdata[ADDR_W-1:0];
      end
      if (is_reg(ph_addr, REG_WDATA) && !busy) begin
        wdata <= hwdata[DQ_W-1:0];
      end
      if (go && !refuse) begin
        cmd <= hwdata[4:0];
      end
    end
  end

  // Error flag: a refused launch sets it, a fresh accepted launch clears it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err <= 1'b0;
    end else if (go) begin
      err <= refuse;
    end
  end

  // [RQ12] unlock spacing timer
  // Counts from the last unlock strobe and saturates at the minimum gap.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap <= 8'(GAP_CYC);
    end else if (clk_en) begin
      if (state == SPG_STROBE && cmd[CMD_UNLOCK] && cnt == 8'h00) begin
        gap <= 8'h00;
      end else if (gap != 8'(GAP_CYC)) begin
        gap <= gap + 8'h01;
      end
    end
  end

  // Cycle sequencer: optional spacing wait, setup, strobe, hold.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SPG_IDLE;
      cnt <= 8'h00;
    end else if (clk_en) begin
      unique case (state)
        SPG_IDLE: begin
          if (go && !refuse) begin
            state <= SPG_WAIT;
          end
        end
        SPG_WAIT: begin
          // [RQ12] hold off unlock
          if (!cmd[CMD_UNLOCK] || gap == 8'(GAP_CYC)) begin
            state <= SPG_SETUP;
          end
        end
        SPG_SETUP: begin
          state <= SPG_STROBE;
          cnt <= 8'(STROBE_CYC);
        end
        SPG_STROBE: begin
          if (cnt == 8'h00) begin
            state <= SPG_HOLD;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        SPG_HOLD: state <= SPG_IDLE;
        default: state <= SPG_IDLE;
      endcase
    end
  end

  // Read data is caught at the end of the output-enable strobe.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= '0;
    end else if (clk_en && state == SPG_STROBE && cnt == 8'h00 && !cmd[CMD_WR]) begin
      rdata <= fl_dq_i;
    end
  end

  // [RQ20] write protect held steady
  // The pin only follows software between sequences; a freeze-set cycle forces it low.
  // The freeze launch wins over software so the pin is low even with no sequence open.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_hold <= 1'b1;
    end else if (clk_en && go && !refuse && hwdata[CMD_FREEZE]) begin
      // [RQ6] freeze under protect
      wp_hold <= 1'b0;
    end else if (clk_en && !ctrl[CTRL_SEQ] && !busy) begin
      wp_hold <= ctrl[CTRL_WP];
    end
  end

  // Flash pins are registered from the sequencer registers, one clock behind the state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fl_addr <= '0;
      fl_dq_o <= '0;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
    end else if (clk_en) begin
      fl_addr <= addr;
      fl_dq_o <= wdata;
      fl_dq_oe <= (state != SPG_IDLE && state != SPG_WAIT) && cmd[CMD_WR];
      fl_ce_n <= !(state == SPG_SETUP || state == SPG_STROBE);
      fl_oe_n <= !(state == SPG_STROBE && cnt != 8'h00 && !cmd[CMD_WR]);
      fl_we_n <= !(state == SPG_STROBE && cnt != 8'h00 && cmd[CMD_WR]);
    end
  end

  assign fl_reset_n = ctrl[CTRL_RST];
  assign write_protect_accel_pin = wp_hold;

  // Helper: time since the previous unlock write strobe began.
  logic [15:0] since;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since <= 16'hffff;
    end else if (!fl_we_n && $past(fl_we_n) && cmd[CMD_UNLOCK]) begin
      since <= 16'h0000;
    end else if (since != 16'hffff) begin
      since <= since + 16'h0001;
    end
  end

  property p_unlock_gap;
    @(posedge hclk) disable iff (!hresetn)
      $fell(fl_we_n) && cmd[CMD_UNLOCK] |-> since >= 16'(GAP_CYC);
  endproperty
  a_unlock_gap: assert property (p_unlock_gap) // [RQ12]
    else $error("unlock strobes closer than the minimum gap");

  sequence s_strobe;
    !fl_we_n || !fl_oe_n;
  endsequence
  property p_wp_steady;
    @(posedge hclk) disable iff (!hresetn)
      s_strobe |-> $stable(write_protect_accel_pin);
  endproperty
  a_wp_steady: assert property (p_wp_steady) // [RQ20]
    else $error("write protect moved during a strobe");

  property p_sect0;
    @(posedge hclk) disable iff (!hresetn)
      $fell(fl_ce_n) && ctrl[CTRL_MODE] && cmd[CMD_ARRAY] |-> !sect0(fl_addr);
  endproperty
  a_sect0: assert property (p_sect0) // [RQ14]
    else $error("array access to sector zero in protection mode");

  sequence s_freeze_go;
    go && !refuse && hwdata[CMD_FREEZE];
  endsequence
  property p_freeze_wp;
    @(posedge hclk) disable iff (!hresetn)
      s_freeze_go ##1 clk_en |-> !write_protect_accel_pin;
  endproperty
  a_freeze_wp: assert property (p_freeze_wp) // [RQ6]
    else $error("freeze set issued with write protect high");
endmodule : spg_ctrl

// File: spg_pkg.sv
/*
  Constants for the host-side controller that drives a parallel flash
  through its pins and applies its sector protection sequences.
  Assumes a single 50 MHz clock and an AHB-Lite bus for software.
*/
// Summary of operation
// [RQ1] Device keeps a volatile per-sector dynamic guard; set writes 0, clear 1.
// [RQ2] Dynamic guard decides only when the persistent guard reads 1.
// [RQ3] Reset loads dynamic guards to a build-time value.
// [RQ4] One volatile freeze bit; 0 blocks persistent guard changes.
// [RQ5] Outside password mode only reset or power-up returns freeze to 1.
// [RQ6] Host sets freeze only after guards are final, holding write protect low.
// [RQ7] Password mode: freeze is 0 after reset; exact 64-bit unlock clears it.
// [RQ8] Password programming only turns ones into zeros.
// [RQ9] Password ships all ones; every 64-bit value is valid.
// [RQ10] Password-mode fuse is permanent and closes the password region.
// [RQ11] Two lowest address bits pick the password part.
// [RQ12] Host spaces password unlock commands at least 1 us apart.
// [RQ13] Unlock takes about 1 us before freeze reads cleared.
// [RQ14] Host enters the mode first; sector 0 is unreachable while in it.
// [RQ15] Program or erase to a protected sector leaves it untouched.
// [RQ16] Separate status reads return dynamic, persistent and freeze bits.
// [RQ17] A sector is open only when both guards read 1.
// [RQ18] Write protect low locks the outermost sector.
// [RQ19] Write protect high leaves that sector to its guards.
// [RQ20] Host keeps write protect steady during a command sequence; spg_ctrl still forces it low on a freeze-set launch with a sequence open.
// [RQ21] Below supply lockout the device ignores writes.
// [RQ22] Power-up with strobes low accepts no command.
// [RQ23] Freeze at 0 makes persistent guard commands time out.
// [RQ24] Scheme register: bit 1 persistent, bit 2 password; both at once aborts.
package spg_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam int CTRL_WP = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_SEQ = 2;
  localparam int CTRL_RST = 3;
  localparam logic [3:0] CTRL_RESET = 4'h9;
  localparam int CMD_WR = 0;
  localparam int CMD_UNLOCK = 1;
  localparam int CMD_PROT = 2;
  localparam int CMD_ARRAY = 3;
  localparam int CMD_FREEZE = 4;
  localparam int ADDR_W = 26;
  localparam int SECT_LSB = 16;
  localparam int DQ_W = 16;
  localparam int CLK_MHZ = 50;
  localparam int GAP_NS = 1000;
  localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [4:0] {
    SPG_IDLE = 5'b00001,
    SPG_WAIT = 5'b00010,
    SPG_SETUP = 5'b00100,
    SPG_STROBE = 5'b01000,
    SPG_HOLD = 5'b10000
  } spg_state_t;
endpackage : spg_pkg

// File: spg_flash_model.sv
/*
  Behavioural flash on the host pins: per-sector guards, one freeze bit, one word per sector.
  Assumes opcodes ride in the upper data byte; this encoding is the model's own choice.
*/
`timescale 1ns/10ps
module spg_flash_model #(
  parameter logic DYN_INIT = 1'b1
) (
  input wire logic [spg_pkg::ADDR_W-1:0] addr,
  input wire logic [spg_pkg::DQ_W-1:0] dq_o,
  input wire logic dq_oe,
  output logic [spg_pkg::DQ_W-1:0] dq_i,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic wp_pin
);
  import spg_pkg::*;
  // power-up loads the dynamic guards to the build option.
  logic [3:0] dyn = {4{DYN_INIT}};
  logic [3:0] pers = 4'hf;
  logic freeze = 1'b1;
  logic powered = 1'b0;
  logic [15:0] mem [4];
  logic [15:0] last = 16'h0;
  logic [15:0] rd;
  logic [1:0] s;
  assign s = addr[SECT_LSB+1:SECT_LSB];
  // no commands until the write strobe has settled high.
  initial begin
    wait (we_n === 1'b1);
    powered = 1'b1;
  end
  function automatic logic open_f(input logic [1:0] k);
    return dyn[k] & pers[k] & !(k == 2'h3 && !wp_pin);
  endfunction : open_f
  always @(posedge we_n or negedge reset_n) begin
    if (!reset_n) begin
      dyn <= {4{DYN_INIT}};
      freeze <= 1'b1;
    end else if (!ce_n && powered) begin
      case (dq_o[15:8])
        8'h60: dyn[s] <= 1'b0;
        8'h61: dyn[s] <= 1'b1;
        8'h68: if (freeze) pers[s] <= 1'b0;
        8'h69: if (freeze) pers <= 4'hf;
        8'h50: freeze <= 1'b0;
        default: if (open_f(s)) mem[s] <= dq_o;
      endcase
    end
  end
  // status reads by low address bits.
  assign rd = (addr[1:0] == 2'h1) ? {15'h0, dyn[s]} : (addr[1:0] == 2'h2) ? {15'h0, pers[s]} :
              (addr[1:0] == 2'h3) ? {15'h0, freeze} : mem[s];
  // A released bus shows the inverse of the last word so stale data cannot pass.
  always @(posedge oe_n) last <= rd;
  assign dq_i = (!ce_n && !oe_n) ? rd : (dq_oe ? dq_o : ~last);
endmodule : spg_flash_model

// File: tb_sector_protection_logic.sv
/*
  Bench for the host protection controller driving the flash model.
  Assumes spg_pkg, spg_ctrl and spg_flash_model are compiled first.
*/
`timescale 1ns/10ps
module tb_sector_protection_logic;
  import spg_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, wp;
  logic [ADDR_W-1:0] fl_addr;
  logic [DQ_W-1:0] fl_dq_o, fl_dq_i;
  int error_cnt = 0, samples_checked = 0, now = 0, fall = 0, gap = 0, width = 0, run = 0, strobes = 0;
  // Free-running 50 MHz clock.
  always #10 hclk = ~hclk;
  spg_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_dq_i(fl_dq_i), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_reset_n(fl_reset_n), .write_protect_accel_pin(wp));
  spg_flash_model u_flash (.addr(fl_addr), .dq_o(fl_dq_o), .dq_oe(fl_dq_oe), .dq_i(fl_dq_i),
    .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .reset_n(fl_reset_n), .wp_pin(wp));
  // Write strobe width, count and spacing in clock cycles.
  always @(posedge hclk) begin
    now <= now + 1;
    run <= fl_we_n ? 0 : run + 1;
    if (!fl_we_n && run == 0) begin
      gap <= now - fall;
      fall <= now;
      strobes <= strobes + 1;
    end
    if (fl_we_n && run != 0) width <= run;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // One edge, then wait for hready under a bound.
  task edge_rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && i < 16) begin
      @(posedge hclk);
      i++;
    end
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: bus never became ready", $time);
      end_sim();
    end
  endtask : edge_rdy
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask : ahb
  // Posts one flash cycle and polls busy; a stuck busy ends the run.
  task cyc(input logic [25:0] a, input logic [15:0] d, input logic [4:0] c);
    ahb(1'b1, REG_ADDR, {6'h0, a});
    ahb(1'b1, REG_WDATA, {16'h0, d});
    ahb(1'b1, REG_CMD, {27'h0, c});
    for (int i = 0; i < 100; i++) begin
      ahb(1'b0, REG_STAT, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (rd[0] !== 1'b0) begin
      error_cnt++;
      $display("Error at %0t: flash cycle stayed busy", $time);
      end_sim();
    end
  endtask : cyc
  task t_basic;
    ahb(1'b0, REG_CTRL, 32'h0);
    chk(rd, {28'h0, CTRL_RESET});
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk(wp, 1'b1);
    cyc(26'h10000, 16'h1234, 5'h09);
    chk(width, STROBE_CYC);
    cyc(26'h10000, 16'h0, 5'h08);
    ahb(1'b0, REG_RDATA, 32'h0);
    chk(rd, 32'h1234);
    $display("t_basic done");
  endtask : t_basic
  task t_refuse;
    int n;
    n = strobes;
    cyc(26'h10000, 16'h6000, 5'h05);
    chk(rd[1], 1'b1);
    ahb(1'b1, REG_CTRL, 32'hb);
    cyc(26'h00000, 16'h0, 5'h09);
    chk(rd[1], 1'b1);
    chk(strobes, n);
    cyc(26'h10000, 16'h0, 5'h08);
    ahb(1'b0, REG_RDATA, 32'h0);
    chk(rd, 32'h1234);
    cyc(26'h10000, 16'h6000, 5'h05);
    cyc(26'h10001, 16'h0, 5'h04);
    ahb(1'b0, REG_RDATA, 32'h0);
    chk(rd, 32'h0);
    $display("t_refuse done");
  endtask : t_refuse
  task t_gap;
    cyc(26'h10000, 16'h7000, 5'h03);
    cyc(26'h10000, 16'h7001, 5'h03);
    chk(gap >= GAP_CYC, 1'b1);
    $display("t_gap done");
  endtask : t_gap
  task t_wp;
    ahb(1'b1, REG_CTRL, 32'hf);
    ahb(1'b1, REG_CTRL, 32'he);
    repeat (4) @(posedge hclk);
    chk(wp, 1'b1);
    ahb(1'b1, REG_CTRL, 32'ha);
    repeat (4) @(posedge hclk);
    chk(wp, 1'b0);
    ahb(1'b1, REG_CTRL, 32'hb);
    ahb(1'b1, REG_CTRL, 32'hf);
    repeat (4) @(posedge hclk);
    chk(wp, 1'b1);
    cyc(26'h10000, 16'h5000, 5'h15);
    chk(wp, 1'b0);
    ahb(1'b1, REG_CTRL, 32'hb);
    repeat (4) @(posedge hclk);
    chk(wp, 1'b1);
    cyc(26'h10003, 16'h0, 5'h04);
    ahb(1'b0, REG_RDATA, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, REG_CTRL, 32'h3);
    repeat (2) @(posedge hclk);
    chk(fl_reset_n, 1'b0);
    ahb(1'b1, REG_CTRL, 32'hb);
    cyc(26'h10003, 16'h0, 5'h04);
    ahb(1'b0, REG_RDATA, 32'h0);
    chk(rd, 32'h1);
    $display("t_wp done");
  endtask : t_wp
  // Main sequence after 20 cycles of reset.
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_basic();
    t_refuse();
    t_gap();
    t_wp();
    end_sim();
  end
endmodule : tb_sector_protection_logic
